// ---- inc/dior_pkg.sv ----
// Shared constants and types for the DSP I/O register bank
package dior_pkg;
  localparam int          CLK_FREQ_KHZ    = 25000;
  localparam int          LOCK_TIME_MS    = 10;
  localparam int          LOCK_CYCLES     = LOCK_TIME_MS * CLK_FREQ_KHZ;
  // Port addresses
  localparam logic [4:0]  OFF_IRQ_MASK    = 5'h04;
  localparam logic [4:0]  OFF_WAIT_CFG    = 5'h08;
  localparam logic [4:0]  OFF_XFER_CTRL   = 5'h09;
  localparam logic [4:0]  OFF_DRAM_COL    = 5'h0A;
  localparam logic [4:0]  OFF_DRAM_ROW    = 5'h0B;
  localparam logic [4:0]  OFF_REPEAT      = 5'h0C;
  localparam logic [4:0]  OFF_CIRC_LEN    = 5'h0D;
  localparam logic [4:0]  OFF_STACK_PTR   = 5'h0F;
  localparam logic [4:0]  OFF_CODEC0      = 5'h10;
  localparam logic [4:0]  OFF_CODEC1      = 5'h11;
  localparam logic [4:0]  OFF_CLK_MULT    = 5'h15;
  // Field positions
  localparam int          CNT_LSB         = 10;
  localparam int          DIR_BIT         = 15;
  localparam int          CODEC_MASK_BIT  = 1;
  localparam int          WAIT_LSB        = 3;
  // Reset values, RAM bank base and last bit index
  localparam logic [12:0] CLK_MULT_RST    = 13'h0014;
  localparam logic [2:0]  WAIT_RST        = 3'h7;
  localparam logic        MASK_RST        = 1'h1;
  localparam logic [15:0] BANK1_BASE      = 16'h0400;
  localparam logic [3:0]  BITS_LAST       = 4'hF;

  typedef enum logic [1:0]
  {
    S_IDLE  = 2'b00,
    S_FETCH = 2'b01,
    S_STORE = 2'b10
  } dior_state_t;

  typedef struct packed
  {
    logic        rd;
    logic        wr;
    logic [14:0] row;
    logic [14:0] col;
    logic [15:0] wdata;
  } dior_dram_t;

  typedef struct packed
  {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dior_ram_t;
endpackage

// ---- verilog/dior_top.sv ----
// I/O register bank: block mover, repeat, circular length, stack pointer, codecs, multiplier
`timescale 1ns/1ps

// ----------------------------------------
// One codec serial channel
// ----------------------------------------
module dior_codec_chan
  import dior_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_fs_rise,
  input  wire logic        i_mclk_rise,
  input  wire logic        i_mclk_fall,
  input  wire logic        i_rxd,
  input  wire logic        i_tx_load,
  input  wire logic [15:0] i_tx_word,
  output logic      [15:0] o_rx_word,
  output logic             o_txd,
  output logic             o_done
);
  logic        rx_busy;
  logic        tx_busy;
  logic [3:0]  rx_cnt;
  logic [3:0]  tx_cnt;
  logic [15:0] rx_sh;
  logic [15:0] tx_sh;
  logic [15:0] tx_hold;
  wire         rx_last = rx_busy && i_mclk_fall && (rx_cnt == BITS_LAST);
  wire         tx_last = tx_busy && i_mclk_rise && (tx_cnt == BITS_LAST);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_busy   <= 1'b0;
      tx_busy   <= 1'b0;
      rx_cnt    <= '0;
      tx_cnt    <= '0;
      rx_sh     <= '0;
      tx_sh     <= '0;
      tx_hold   <= '0;
      o_rx_word <= '0;
      o_txd     <= 1'b0;
      o_done    <= 1'b0;
    end
    else
    begin
      if (i_tx_load)
        tx_hold <= i_tx_word;
      if (i_fs_rise)
      begin
        rx_busy <= 1'b1;
        rx_cnt  <= '0;
        tx_busy <= 1'b1;
        tx_cnt  <= '0;
        tx_sh   <= tx_hold;
      end
      else
      begin
        if (rx_busy && i_mclk_fall)
        begin
          rx_sh  <= {rx_sh[14:0], i_rxd};
          rx_cnt <= rx_cnt + 4'h1;
        end
        if (rx_last)
        begin
          rx_busy   <= 1'b0;
          o_rx_word <= {rx_sh[14:0], i_rxd};
        end
        if (tx_busy && i_mclk_rise)
        begin
          o_txd  <= tx_sh[15];
          tx_sh  <= {tx_sh[14:0], 1'b0};
          tx_cnt <= tx_cnt + 4'h1;
        end
        if (tx_last)
          tx_busy <= 1'b0;
      end
      o_done <= rx_last || tx_last;
    end
  end
endmodule

// ----------------------------------------
// Register bank top
// ----------------------------------------
module dior_top
  import dior_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_CYCLES
)
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RSTN,
  input  wire logic [4:0]  I_IO_ADDR,
  input  wire logic        I_IO_WR,
  input  wire logic        I_IO_RD,
  input  wire logic [15:0] I_IO_WDATA,
  output logic      [15:0] O_IO_RDATA,
  output logic             O_CORE_HOLD,
  output dior_dram_t       O_DRAM,
  input  wire logic [15:0] I_DRAM_RDATA,
  output dior_ram_t        O_RAM,
  input  wire logic [15:0] I_RAM_RDATA,
  input  wire logic        I_RPT_LOAD,
  input  wire logic [9:0]  I_RPT_VALUE,
  input  wire logic        I_REP_STEP,
  output logic             O_REP_LAST,
  input  wire logic        I_MOD_LOAD,
  input  wire logic [9:0]  I_MOD_VALUE,
  input  wire logic        I_AR_UPDATE,
  input  wire logic [15:0] I_AR_CUR,
  input  wire logic [15:0] I_AR_STEP,
  output logic      [15:0] O_AR_NEXT,
  input  wire logic        I_PUSH,
  input  wire logic        I_POP,
  output logic      [4:0]  O_STACK_PTR,
  input  wire logic        I_CODEC_MCLK,
  input  wire logic        I_CODEC_FS,
  input  wire logic        I_CODEC_RXD0,
  input  wire logic        I_CODEC_RXD1,
  output logic             O_CODEC_TXD0,
  output logic             O_CODEC_TXD1,
  output logic             O_CODEC_IRQ,
  output logic      [12:0] O_CLK_MULT,
  output logic             O_CLK_LOCKED
);
  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic        rst_ff1;
  logic        rst_n;
  logic [3:0]  pin_s1;
  logic [3:0]  pin_s2;
  logic [1:0]  pin_prev;

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rst_ff1 <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rst_ff1 <= 1'b1;
      rst_n   <= rst_ff1;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1   <= '0;
      pin_s2   <= '0;
      pin_prev <= '0;
    end
    else
    begin
      pin_s1   <= {I_CODEC_RXD1, I_CODEC_RXD0, I_CODEC_FS, I_CODEC_MCLK};
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2[1:0];
    end
  end

  wire mclk_rise = pin_s2[0] && !pin_prev[0];
  wire mclk_fall = !pin_s2[0] && pin_prev[0];
  wire fs_rise   = pin_s2[1] && !pin_prev[1];

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic [5:0]  xfer_cnt;
  logic [9:0]  ram_off;
  logic [14:0] col_start;
  logic [15:0] row_dir;
  logic [2:0]  wait_st;
  logic        codec_mask;
  logic [9:0]  rep_cnt;
  logic [9:0]  circ_len;
  logic [4:0]  sp;
  logic [15:0] rx_word0;
  logic [15:0] rx_word1;
  logic [1:0]  codec_done;
  dior_state_t state;

  wire wr_xfer  = I_IO_WR && (I_IO_ADDR == OFF_XFER_CTRL);
  wire wr_col   = I_IO_WR && (I_IO_ADDR == OFF_DRAM_COL);
  wire wr_row   = I_IO_WR && (I_IO_ADDR == OFF_DRAM_ROW);
  wire wr_mask  = I_IO_WR && (I_IO_ADDR == OFF_IRQ_MASK);
  wire wr_wait  = I_IO_WR && (I_IO_ADDR == OFF_WAIT_CFG);
  wire wr_cdc0  = I_IO_WR && (I_IO_ADDR == OFF_CODEC0);
  wire wr_cdc1  = I_IO_WR && (I_IO_ADDR == OFF_CODEC1);
  wire wr_mult  = I_IO_WR && (I_IO_ADDR == OFF_CLK_MULT);
  wire [5:0] wr_cnt = I_IO_WDATA[15:CNT_LSB];
  wire start    = wr_xfer && (state == S_IDLE) && (wr_cnt != 6'h00);

  logic [15:0] rd_mux;
  always_comb
  begin
    case (I_IO_ADDR)
      OFF_IRQ_MASK:  rd_mux = 16'(codec_mask) << CODEC_MASK_BIT;
      OFF_WAIT_CFG:  rd_mux = 16'(wait_st) << WAIT_LSB;
      OFF_XFER_CTRL: rd_mux = {xfer_cnt, ram_off};
      OFF_DRAM_COL:  rd_mux = {1'b0, col_start};
      OFF_DRAM_ROW:  rd_mux = row_dir;
      OFF_REPEAT:    rd_mux = {6'h00, rep_cnt};
      OFF_CIRC_LEN:  rd_mux = {6'h00, circ_len};
      OFF_STACK_PTR: rd_mux = {11'h000, sp};
      OFF_CODEC0:    rd_mux = rx_word0;
      OFF_CODEC1:    rd_mux = rx_word1;
      default:       rd_mux = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // Programmable registers
  // ----------------------------------------
  logic [17:0] lock_cnt;
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_IO_RDATA   <= '0;
      col_start    <= '0;
      row_dir      <= '0;
      wait_st      <= WAIT_RST;
      codec_mask   <= MASK_RST;
      O_CLK_MULT   <= CLK_MULT_RST;
      lock_cnt     <= '0;
      O_CLK_LOCKED <= 1'b0;
      O_CODEC_IRQ  <= 1'b0;
    end
    else
    begin
      if (I_IO_RD)
        O_IO_RDATA <= rd_mux;
      if (wr_col)
        col_start <= I_IO_WDATA[14:0];
      if (wr_row)
        row_dir <= I_IO_WDATA;
      if (wr_wait)
        wait_st <= I_IO_WDATA[WAIT_LSB +: 3];
      if (wr_mask)
        codec_mask <= I_IO_WDATA[CODEC_MASK_BIT];
      if (wr_mult)
      begin
        O_CLK_MULT   <= I_IO_WDATA[12:0];
        lock_cnt     <= '0;
        O_CLK_LOCKED <= 1'b0;
      end
      else if (lock_cnt == 18'(LOCK_CYC - 1))
        O_CLK_LOCKED <= 1'b1;
      else
        lock_cnt <= lock_cnt + 18'h1;
      O_CODEC_IRQ <= (|codec_done) && !codec_mask;
    end
  end

  // ----------------------------------------
  // Block mover
  // ----------------------------------------
  logic [29:0] dram_ptr;
  logic [9:0]  ram_ptr;
  logic [2:0]  wcnt;
  logic [15:0] buf_word;
  logic        dram_rd;
  logic        dram_wr;
  logic        ram_rd;
  logic        ram_wr;
  wire         dir_in = row_dir[DIR_BIT];

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state       <= S_IDLE;
      xfer_cnt    <= '0;
      ram_off     <= '0;
      dram_ptr    <= '0;
      ram_ptr     <= '0;
      wcnt        <= '0;
      buf_word    <= '0;
      O_CORE_HOLD <= 1'b0;
      dram_rd     <= 1'b0;
      dram_wr     <= 1'b0;
      ram_rd      <= 1'b0;
      ram_wr      <= 1'b0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (wr_xfer)
          begin
            xfer_cnt <= wr_cnt;
            ram_off  <= I_IO_WDATA[9:0];
          end
          if (start)
          begin
            state       <= S_FETCH;
            O_CORE_HOLD <= 1'b1;
            ram_ptr     <= I_IO_WDATA[9:0];
            dram_ptr    <= {row_dir[14:0], col_start};
            wcnt        <= dir_in ? wait_st : 3'h0;
            dram_rd     <= dir_in;
            ram_rd      <= !dir_in;
          end
        end
        S_FETCH:
        begin
          if (wcnt != 3'h0)
            wcnt <= wcnt - 3'h1;
          else
          begin
            buf_word  <= dir_in ? I_DRAM_RDATA : I_RAM_RDATA;
            dram_rd   <= 1'b0;
            ram_rd    <= 1'b0;
            dram_wr   <= !dir_in;
            ram_wr    <= dir_in;
            wcnt      <= dir_in ? 3'h0 : wait_st;
            state     <= S_STORE;
          end
        end
        S_STORE:
        begin
          if (wcnt != 3'h0)
            wcnt <= wcnt - 3'h1;
          else
          begin
            dram_wr   <= 1'b0;
            ram_wr    <= 1'b0;
            xfer_cnt  <= xfer_cnt - 6'h01;
            ram_ptr   <= ram_ptr + 10'h001;
            dram_ptr  <= dram_ptr + 30'h00000001;
            if (xfer_cnt == 6'h01)
            begin
              state       <= S_IDLE;
              O_CORE_HOLD <= 1'b0;
            end
            else
            begin
              state     <= S_FETCH;
              wcnt      <= dir_in ? wait_st : 3'h0;
              dram_rd   <= dir_in;
              ram_rd    <= !dir_in;
            end
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // Bank 1 base has clear low bits, so the offset drops straight in
  assign O_DRAM = {dram_rd, dram_wr, dram_ptr, buf_word};
  assign O_RAM  = {ram_rd, ram_wr, BANK1_BASE[15:10], ram_ptr, buf_word};

  // ----------------------------------------
  // Repeat, circular addressing, stack
  // ----------------------------------------
  wire [9:0]  circ_m1   = circ_len | (circ_len >> 1);
  wire [9:0]  circ_m2   = circ_m1 | (circ_m1 >> 2);
  wire [9:0]  circ_m4   = circ_m2 | (circ_m2 >> 4);
  wire [9:0]  circ_mask = circ_m4 | (circ_m4 >> 8);
  wire [15:0] circ_base = I_AR_CUR & ~{6'h00, circ_mask};
  wire [9:0]  circ_low  = I_AR_CUR[9:0] & circ_mask;
  wire        step_up   = !I_AR_STEP[15] && (I_AR_STEP != 16'h0000);
  wire        at_top    = step_up && (circ_low == circ_len);
  wire        at_bot    = I_AR_STEP[15] && (circ_low == 10'h000);
  logic [15:0] ar_calc;
  always_comb
  begin
    if (circ_len == 10'h000)
      ar_calc = I_AR_CUR + I_AR_STEP;
    else if (at_top)
      ar_calc = circ_base;
    else if (at_bot)
      ar_calc = circ_base + {6'h00, circ_len};
    else
      ar_calc = I_AR_CUR + I_AR_STEP;
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rep_cnt    <= '0;
      O_REP_LAST <= 1'b1;
      circ_len   <= '0;
      O_AR_NEXT  <= '0;
      sp         <= '0;
    end
    else
    begin
      if (I_RPT_LOAD)
      begin
        rep_cnt    <= I_RPT_VALUE;
        O_REP_LAST <= (I_RPT_VALUE == 10'h000);
      end
      else if (I_REP_STEP && rep_cnt != 10'h000)
      begin
        rep_cnt    <= rep_cnt - 10'h001;
        O_REP_LAST <= (rep_cnt == 10'h001);
      end
      if (I_MOD_LOAD)
        circ_len <= I_MOD_VALUE;
      if (I_AR_UPDATE)
        O_AR_NEXT <= ar_calc;
      if (I_PUSH && !I_POP)
        sp <= sp + 5'h01;
      else if (I_POP && !I_PUSH)
        sp <= sp - 5'h01;
    end
  end

  assign O_STACK_PTR = sp;

  // ----------------------------------------
  // Codec channels
  // ----------------------------------------
  dior_codec_chan u_codec0
  (
    .i_clk       (I_SYS_CLK),
    .i_rst_n     (rst_n),
    .i_fs_rise   (fs_rise),
    .i_mclk_rise (mclk_rise),
    .i_mclk_fall (mclk_fall),
    .i_rxd       (pin_s2[2]),
    .i_tx_load   (wr_cdc0),
    .i_tx_word   (I_IO_WDATA),
    .o_rx_word   (rx_word0),
    .o_txd       (O_CODEC_TXD0),
    .o_done      (codec_done[0])
  );

  dior_codec_chan u_codec1
  (
    .i_clk       (I_SYS_CLK),
    .i_rst_n     (rst_n),
    .i_fs_rise   (fs_rise),
    .i_mclk_rise (mclk_rise),
    .i_mclk_fall (mclk_fall),
    .i_rxd       (pin_s2[3]),
    .i_tx_load   (wr_cdc1),
    .i_tx_word   (I_IO_WDATA),
    .o_rx_word   (rx_word1),
    .o_txd       (O_CODEC_TXD1),
    .o_done      (codec_done[1])
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!rst_n);

  sequence word_stored;
    (state == S_STORE) && (wcnt == 3'h0);
  endsequence

  xfer_start_a: assert property (start |=> O_CORE_HOLD && state == S_FETCH)
    else $error("block move did not start");
  hold_clear_a: assert property ($fell(O_CORE_HOLD) |-> xfer_cnt == 6'h00)
    else $error("count not zero after move");
  cnt_step_a: assert property (word_stored |=> xfer_cnt == $past(xfer_cnt) - 6'h01)
    else $error("count did not step per word");
  addr_step_a: assert property (word_stored |=> ram_ptr == $past(ram_ptr) + 10'h001)
    else $error("ram pointer did not advance");
  dir_write_a: assert property (O_DRAM.wr |-> !row_dir[DIR_BIT] && !O_RAM.wr)
    else $error("dram written in wrong direction");
  rep_dec_a: assert property (I_REP_STEP && !I_RPT_LOAD && rep_cnt != 10'h000
                              |=> rep_cnt == $past(rep_cnt) - 10'h001)
    else $error("repeat counter did not decrement");
  sp_wrap_a: assert property (I_PUSH && !I_POP && sp == 5'h1F |=> sp == 5'h00)
    else $error("stack pointer did not wrap");
  circ_wrap_a: assert property (I_AR_UPDATE && circ_len != 10'h000 && at_top
                                |=> O_AR_NEXT == $past(circ_base))
    else $error("circular pointer did not wrap");
  irq_mask_a: assert property (O_CODEC_IRQ |-> $past(codec_mask) == 1'b0
                               && $past(codec_done) != 2'b00)
    else $error("masked codec interrupt raised");
endmodule

// ---- tb/dior_far_model.sv ----
// Far-side model: DRAM array and two-channel codec frame source
`timescale 1ns/1ps
module dior_far_model
  import dior_pkg::*;
(
  input  wire logic        i_clk,
  input  wire dior_dram_t  i_dram,
  output logic      [15:0] o_dram_rdata,
  input  wire logic        i_go,
  input  wire logic [31:0] i_rx,
  output logic             o_mclk,
  output logic             o_fs,
  output logic      [1:0]  o_rxd,
  input  wire logic [1:0]  i_txd,
  output logic      [31:0] o_tx,
  output logic             o_busy
);
  logic [15:0] mem [64];
  initial
  begin
    for (int i = 0; i < 64; i++)
      mem[i] = 16'hC000 ^ (16'(i) * 16'h0107);
    {o_mclk, o_fs, o_rxd, o_tx, o_busy} = '0;
  end
  // Released data lines show the inverse word
  assign o_dram_rdata = mem[i_dram.col[5:0]] ^ {16{i_dram.rd !== 1'b1}};
  always @(posedge i_clk)
    if (i_dram.wr === 1'b1)
      mem[i_dram.col[5:0]] <= i_dram.wdata;
  // Codec clock stands still outside frames
  always @(posedge i_clk)
    if (i_go && !o_busy)
    begin
      o_busy <= 1'b1;
      o_fs <= 1'b1;
      repeat (8) @(posedge i_clk);
      for (int b = 15; b >= 0; b--)
      begin
        o_mclk <= 1'b1;
        o_rxd <= {i_rx[16 + b], i_rx[b]};
        repeat (4) @(posedge i_clk);
        o_mclk <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_tx[16 + b] <= i_txd[1];
        o_tx[b] <= i_txd[0];
      end
      o_fs <= 1'b0;
      o_rxd <= ~o_rxd;
      repeat (8) @(posedge i_clk);
      o_busy <= 1'b0;
    end
endmodule

// ---- tb/dior_top_bench.sv ----
// Self-checking bench for the I/O register bank
`timescale 1ns/1ps
module dior_top_bench
  import dior_pkg::*;
;
  localparam int LK = 16;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic [4:0]  addr = '0, sp;
  logic [15:0] wdata = '0, ar_cur = '0, ar_step = '0, rdata, ram_rd, dram_rd, ar_nx;
  logic [9:0]  rpt_v = '0, mod_v = '0;
  logic [5:0]  pl = '0;
  logic [31:0] rxw = '0, txw;
  logic [1:0]  rxd, txd;
  logic [12:0] mult;
  logic        hold, last, mclk, fs, irq, locked, fbusy;
  logic [14:0] erow = '0;
  logic [15:0] ramw [1024];
  dior_dram_t  dram;
  dior_ram_t   ram;
  int          failures = 0, checks = 0, irqs = 0, seed = 32'h107A50D7;

  dior_top #(.LOCK_CYC(LK)) u_dut (
    .I_SYS_CLK(clk), .I_RSTN(rst_n), .I_IO_ADDR(addr), .I_IO_WR(wr), .I_IO_RD(rd),
    .I_IO_WDATA(wdata), .O_IO_RDATA(rdata), .O_CORE_HOLD(hold), .O_DRAM(dram),
    .I_DRAM_RDATA(dram_rd), .O_RAM(ram), .I_RAM_RDATA(ram_rd), .I_RPT_LOAD(pl[0]),
    .I_RPT_VALUE(rpt_v), .I_REP_STEP(pl[1]), .O_REP_LAST(last), .I_MOD_LOAD(pl[2]),
    .I_MOD_VALUE(mod_v), .I_AR_UPDATE(pl[3]), .I_AR_CUR(ar_cur), .I_AR_STEP(ar_step),
    .O_AR_NEXT(ar_nx), .I_PUSH(pl[5]), .I_POP(pl[4]), .O_STACK_PTR(sp),
    .I_CODEC_MCLK(mclk), .I_CODEC_FS(fs), .I_CODEC_RXD0(rxd[0]), .I_CODEC_RXD1(rxd[1]),
    .O_CODEC_TXD0(txd[0]), .O_CODEC_TXD1(txd[1]), .O_CODEC_IRQ(irq), .O_CLK_MULT(mult),
    .O_CLK_LOCKED(locked));
  dior_far_model u_far (.i_clk(clk), .i_dram(dram), .o_dram_rdata(dram_rd), .i_go(go),
    .i_rx(rxw), .o_mclk(mclk), .o_fs(fs), .o_rxd(rxd), .i_txd(txd), .o_tx(txw),
    .o_busy(fbusy));

  // Internal RAM gives the true word only while read is high, else its inverse
  assign ram_rd = (ram.addr ^ 16'h5A3C) ^ {16{ram.rd !== 1'b1}};
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (irq === 1'b1)
      irqs++;
    if (ram.wr === 1'b1)
      ramw[ram.addr[9:0]] <= ram.wdata;
    if (dram.rd === 1'b1 || dram.wr === 1'b1)
      chk(16'(dram.row), 16'(erow), "dram row");
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic bound(input logic ok, input string m);
    chk(16'(ok), 16'h0001, m);
    if (!ok)
      give_verdict();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic io_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic io_rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    tick(1);
    d = rdata;
  endtask
  task automatic pulse(input logic [5:0] p);
    @(posedge clk);
    pl <= p;
    @(posedge clk);
    pl <= '0;
    tick(1);
  endtask
  task automatic ar_chk(input logic [15:0] c, input logic [15:0] s, input logic [15:0] e);
    @(posedge clk);
    ar_cur <= c;
    ar_step <= s;
    pulse(6'h08);
    chk(ar_nx, e, "next address");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic move(input logic dir, input logic [5:0] n, input logic [2:0] w);
    logic [9:0]  off;
    logic [5:0]  col;
    logic [15:0] d;
    int          hc;
    off = 10'($random(seed)) & 10'h3BF;
    col = 6'($random(seed)) & 6'h1F;
    erow = 15'($random(seed));
    hc = 0;
    io_wr(OFF_WAIT_CFG, 16'(w) << WAIT_LSB);
    io_wr(OFF_DRAM_COL, 16'(col));
    io_wr(OFF_DRAM_ROW, {dir, erow});
    io_wr(OFF_XFER_CTRL, {n, off});
    #1;
    for (int i = 0; i < 3000 && (hc == 0 || hold === 1'b1); i++)
    begin
      if (hold === 1'b1)
        hc++;
      tick(1);
    end
    bound(hold === 1'b0 && hc > 0, "move end");
    chk(16'(hc), 16'(n * (w + 2)), "hold length");
    io_rd(OFF_XFER_CTRL, d);
    chk(d, {6'h00, off}, "count cleared");
    for (int i = 0; i < n; i++)
      if (dir)
        chk(ramw[off + i], 16'hC000 ^ (16'(col + i) * 16'h0107), "to ram");
      else
        chk(u_far.mem[col + i], (16'h0400 + 16'(off + i)) ^ 16'h5A3C, "to dram");
  endtask
  task automatic frame(input logic wm, input logic [15:0] mask, input logic ex);
    logic [31:0] tw;
    logic [31:0] rw;
    logic [15:0] d;
    tw = $random(seed);
    rw = $random(seed);
    if (wm)
      io_wr(OFF_IRQ_MASK, mask);
    io_wr(OFF_CODEC0, tw[15:0]);
    io_wr(OFF_CODEC1, tw[31:16]);
    irqs = 0;
    rxw <= rw;
    go <= 1'b1;
    tick(2);
    go <= 1'b0;
    for (int i = 0; i < 400 && fbusy === 1'b1; i++)
      tick(1);
    bound(fbusy === 1'b0, "frame end");
    io_rd(OFF_CODEC0, d);
    chk(d, rw[15:0], "rx word 0");
    io_rd(OFF_CODEC1, d);
    chk(d, rw[31:16], "rx word 1");
    chk(txw[15:0], tw[15:0], "tx word 0");
    chk(txw[31:16], tw[31:16], "tx word 1");
    chk(16'(irqs > 0), 16'(ex), "codec irq");
  endtask
  task automatic misc();
    logic [4:0]  ra [9] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h1F, 5'h04, 5'h08};
    logic [15:0] d;
    logic [9:0]  v;
    logic [15:0] b;
    int          k;
    for (int i = 0; i < 9; i++)
    begin
      io_rd(ra[i], d);
      chk(d, i < 7 ? 16'h0000 : (i == 7 ? 16'h0002 : 16'h0038), "reset value");
    end
    chk(16'(mult), 16'h0014, "mult reset");
    v = 10'(2 + ($random(seed) & 7));
    rpt_v <= v;
    pulse(6'h01);
    io_wr(OFF_REPEAT, 16'h03FF);
    io_rd(OFF_REPEAT, d);
    chk(d, 16'(v), "repeat load");
    for (int i = 0; i < v; i++)
    begin
      chk(16'(last), 16'h0000, "not last");
      pulse(6'h02);
    end
    chk(16'(last), 16'h0001, "last pass");
    mod_v <= 10'(3 + ($random(seed) & 255));
    pulse(6'h04);
    io_rd(OFF_CIRC_LEN, d);
    chk(d, 16'(mod_v), "circ length");
    k = 1;
    while (k < d + 1)
      k = k * 2;
    b = 16'($random(seed)) & ~16'(k - 1);
    ar_chk(b + d, 16'h0001, b);
    ar_chk(b, 16'hFFFF, b + d);
    ar_chk(b + 16'h0001, 16'h0002, b + 16'h0003);
    mod_v <= '0;
    pulse(6'h04);
    ar_chk(b + d, 16'h0001, b + d + 16'h0001);
    pulse(6'h10);
    chk(16'(sp), 16'h001F, "underflow");
    pulse(6'h20);
    chk(16'(sp), 16'h0000, "overflow");
    repeat (5) pulse(6'h20);
    io_wr(OFF_STACK_PTR, 16'h0011);
    io_rd(OFF_STACK_PTR, d);
    chk(d, 16'h0005, "stack read");
    io_wr(OFF_CLK_MULT, 16'(12 + ($random(seed) & 7)));
    tick(LK - 4);
    chk(16'(locked), 16'h0000, "locking");
    for (int i = 0; i < 8 && locked !== 1'b1; i++)
      tick(1);
    chk(16'(locked), 16'h0001, "locked");
    chk(16'(mult), wdata, "multiplier");
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    misc();
    $display("registers done");
    move(1'b1, 6'h01, 3'h0);
    for (int k = 0; k < 6; k++)
      move(k < 3, 6'(1 + ($random(seed) & 31)), 3'($random(seed)));
    move(1'b0, 6'h01, 3'h7);
    $display("moves done");
    frame(1'b0, 16'h0000, 1'b0);
    frame(1'b1, 16'h0000, 1'b1);
    frame(1'b1, 16'h0002, 1'b0);
    $display("codec done");
    give_verdict();
  end
endmodule
